//--- slcm_defs.svh
// Constants for the scan list configuration memory: offsets, fields, sizes.
`ifndef SLCM_DEFS_SVH
`define SLCM_DEFS_SVH

// Direct I/O offsets inside the card's 32-byte window
`define SLCM_OFF_WIN_PTR 5'h00
`define SLCM_OFF_WIN_WDATA 5'h02
`define SLCM_OFF_WIN_RDATA 5'h04
`define SLCM_OFF_ENTRY_LO 5'h10
`define SLCM_OFF_ENTRY_HI 5'h12
`define SLCM_OFF_FIFO_DATA 5'h1C

// Windowed strobe addresses
`define SLCM_WIN_LIST_CLR 8'h52
`define SLCM_WIN_FIFO_CLR 8'h53

// Low word field positions
`define SLCM_LO_END_BIT 15
`define SLCM_LO_DITHER_BIT 9
`define SLCM_LO_UNIP_BIT 8
`define SLCM_LO_GAIN_MSB 2

// High word field positions
`define SLCM_HI_KIND_MSB 14
`define SLCM_HI_KIND_LSB 12
`define SLCM_HI_CHAN_MSB 3

// Input kind codes
`define SLCM_KIND_CAL 3'h0
`define SLCM_KIND_DIFF 3'h1
`define SLCM_KIND_FSE 3'h2
`define SLCM_KIND_GSE 3'h3
`define SLCM_KIND_SKIP 3'h7

// Amplifier input selector codes (0..15 are analog input pins)
`define SLCM_SEL_GND 5'h10
`define SLCM_SEL_REF5 5'h11
`define SLCM_SEL_SENSE 5'h12
`define SLCM_SEL_NONE 5'h1F

// Calibration channel codes
`define SLCM_CAL_OFFSET 4'h0
`define SLCM_CAL_GAIN 4'h5

// Sizes
`define SLCM_DEPTH 16
`define SLCM_IDXW 4
`define SLCM_FIFO_DEPTH 8
`define SLCM_FIFO_AW 3
`define SLCM_ADC_BITS 12
`define SLCM_DATA_BITS 16

`endif

//--- slcm_pkg.sv
// Types shared by the scan list configuration memory modules.
`include "slcm_defs.svh"
package slcm_pkg;

    // One stored scan-list entry
    typedef struct packed {
        logic end_flag;       // Scan ends after this entry
        logic noise_inject_on; // Dither request
        logic unipolar;       // 1 = straight binary
        logic [2:0] gain;     // Amplifier gain code
        logic [2:0] input_kind_code; // Input kind
        logic [3:0] chan;     // Channel code
    } slcm_entry_t;

    // Amplifier routing decided for one entry
    typedef struct packed {
        logic [4:0] pos_sel;  // Positive amp input
        logic [4:0] neg_sel;  // Negative amp input
        logic acquire;        // Result goes to the queue
    } slcm_route_t;

    // Sequencer states
    typedef enum logic {
        SCAN_IDLE,
        SCAN_RUN
    } slcm_scan_t;

endpackage : slcm_pkg

//--- slcm_router.sv
// Input kind and channel code to amplifier routing decode.
`include "slcm_defs.svh"
module slcm_router (
    // Entry in
    input wire slcm_pkg::slcm_entry_t entry,
    // Routing out
    output slcm_pkg::slcm_route_t route
);

    // Pure decode; the caller registers the result
    always_comb begin
        route.pos_sel = `SLCM_SEL_NONE;
        route.neg_sel = `SLCM_SEL_NONE;
        route.acquire = 1'b0;
        case (entry.input_kind_code)
            `SLCM_KIND_CAL: begin
                // Offset: ground on both sides [R14]
                if (entry.chan == `SLCM_CAL_OFFSET) begin
                    route.pos_sel = `SLCM_SEL_GND;
                    route.neg_sel = `SLCM_SEL_GND;
                    route.acquire = 1'b1;
                end else if (entry.chan == `SLCM_CAL_GAIN) begin
                    // Gain: reference against ground [R14]
                    route.pos_sel = `SLCM_SEL_REF5;
                    route.neg_sel = `SLCM_SEL_GND;
                    route.acquire = 1'b1;
                end
            end
            `SLCM_KIND_DIFF: begin
                // Pin n against pin n+8; top bit set is reserved [R15]
                if (!entry.chan[3]) begin
                    route.pos_sel = {1'b0, entry.chan};
                    route.neg_sel = {1'b0, 1'b1, entry.chan[2:0]};
                    route.acquire = 1'b1;
                end
            end
            `SLCM_KIND_FSE: begin
                // Pin n against the sense return [R16] [R13]
                route.pos_sel = {1'b0, entry.chan};
                route.neg_sel = `SLCM_SEL_SENSE;
                route.acquire = 1'b1;
            end
            `SLCM_KIND_GSE: begin
                // Pin n against analog ground [R17] [R13]
                route.pos_sel = {1'b0, entry.chan};
                route.neg_sel = `SLCM_SEL_GND;
                route.acquire = 1'b1;
            end
            // Skip and invalid kinds: nothing routed, nothing kept [R12] [R18]
            default: route.acquire = 1'b0;
        endcase
    end

endmodule : slcm_router

//--- slcm_sample_fifo.sv
// Conversion result queue held in flip-flops, with flush.
`include "slcm_defs.svh"
module slcm_sample_fifo (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Write side
    input wire logic push,
    input wire logic [`SLCM_DATA_BITS-1:0] push_data,
    // Read side
    input wire logic pop,
    output logic [`SLCM_DATA_BITS-1:0] head,
    output logic empty,
    output logic full,
    // Discard everything
    input wire logic flush
);

    // Whole state of the queue
    typedef struct packed {
        logic [`SLCM_FIFO_DEPTH-1:0][`SLCM_DATA_BITS-1:0] mem;
        logic [`SLCM_FIFO_AW-1:0] wp;
        logic [`SLCM_FIFO_AW-1:0] rp;
        logic [`SLCM_FIFO_AW:0] cnt;
    } slcm_fifo_st_t;

    slcm_fifo_st_t s_ff;
    slcm_fifo_st_t nxt_s;
    logic do_push;
    logic do_pop;

    assign empty = (s_ff.cnt == '0);
    assign full = (s_ff.cnt == (`SLCM_FIFO_AW+1)'(`SLCM_FIFO_DEPTH));
    assign head = s_ff.mem[s_ff.rp];

    // Pointer update; a push on a full queue is dropped
    always_comb begin
        nxt_s = s_ff;
        do_push = push && !full;
        do_pop = pop && !empty;
        if (do_push) begin
            nxt_s.mem[s_ff.wp] = push_data;
            nxt_s.wp = s_ff.wp + 1'b1;
        end
        if (do_pop) begin
            nxt_s.rp = s_ff.rp + 1'b1;
        end
        nxt_s.cnt = s_ff.cnt + {{`SLCM_FIFO_AW{1'b0}}, do_push} - {{`SLCM_FIFO_AW{1'b0}}, do_pop};
        // Flush beats a same-cycle push [R20]
        if (flush) begin
            nxt_s.wp = '0;
            nxt_s.rp = '0;
            nxt_s.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule : slcm_sample_fifo

//--- slcm_scan_list.sv
// Scan list configuration memory: I/O bus slave, list store and scan stepping.
//
// Summary of operation
// [R1] Store entries; step through them in order
// [R2] Low word write-only at offset 0x10
// [R3] High word write-only at 0x12, kind/channel
// [R4] Low bit 15 set marks scan end
// [R5] Many end flags: separate scans, interval mode
// [R6] Host writes zero to unused bits
// [R7] Low bit 9 enables input dither
// [R8] Fixed-dither variant: bit ignored, forced on
// [R9] Low bit 8: one unipolar, zero bipolar
// [R10] Bipolar results sign-extended to 16 bits
// [R11] Low bits 2..0 select amplifier gain
// [R12] High bits 14..12 give input kind
// [R13] High bits 3..0 select the channel
// [R14] Calibration: code 0 offset, 5 gain
// [R15] Differential: pin n against n+8
// [R16] Floating single-ended: pin against sense return
// [R17] Grounded single-ended: pin against analog ground
// [R18] Skip entry keeps slot, no acquisition
// [R19] Windowed 0x52 access erases list, pointer zero
// [R20] Windowed 0x53 access empties sample queue
// [R21] Strobes ignore data, act on access
// [R22] Push each result except skip entries; code also drops results of reserved and invalid entries
// [R23] Host reaches windowed registers via pointer
// [R24] Commit entry once both words written
// [R25] Continuous scan restarts from first entry
`include "slcm_defs.svh"
module slcm_scan_list #(
    // 1 on the card variant whose dither cannot be switched off
    parameter logic DITHER_FIXED = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Card I/O bus
    input wire logic [4:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    // Timing controller
    input wire logic scan_start,
    input wire logic interval_mode,
    input wire logic conv_done,
    input wire logic [`SLCM_ADC_BITS-1:0] adc_code,
    output logic scan_active,
    output logic scan_done,
    // Analog front end control
    output logic [4:0] amp_pos_sel,
    output logic [4:0] amp_neg_sel,
    output logic [2:0] amp_gain,
    output logic adc_unipolar,
    output logic dither_on,
    output logic entry_acquire,
    // Sample queue flags
    output logic fifo_empty,
    output logic fifo_full
);

    // All state of this module
    typedef struct packed {
        slcm_pkg::slcm_entry_t [`SLCM_DEPTH-1:0] mem; // The list itself
        logic [`SLCM_IDXW:0] count;     // Entries stored, also write pointer
        logic [`SLCM_IDXW-1:0] rd_idx;  // Entry being converted
        slcm_pkg::slcm_scan_t scan_st;  // Sequencer state
        logic [7:0] win_ptr;            // Window pointer
        logic [15:0] lo_word;           // Pending low half
        logic [15:0] hi_word;           // Pending high half
        logic got_lo;                   // Low half arrived
        logic got_hi;                   // High half arrived
        logic [15:0] rdata;             // Read data out
        slcm_pkg::slcm_route_t route;   // Registered routing
        logic [2:0] gain;               // Registered gain
        logic unipolar;                 // Registered polarity
        logic dither;                   // Registered dither
        logic scan_active;              // In a scan
        logic scan_done;                // Scan end pulse
        logic fifo_empty;               // Registered flag
        logic fifo_full;                // Registered flag
    } slcm_st_t;

    slcm_st_t s_ff;
    slcm_st_t nxt_s;

    // Decoded bus events
    logic wr_lo;
    logic wr_hi;
    logic win_access;
    logic list_clr;
    logic fifo_clr;
    logic fifo_pop;
    logic commit;
    slcm_pkg::slcm_entry_t new_entry;
    slcm_pkg::slcm_entry_t cur_entry;
    slcm_pkg::slcm_route_t cur_route;
    logic last_slot;
    logic res_push;
    logic [`SLCM_DATA_BITS-1:0] res_data;
    logic [`SLCM_DATA_BITS-1:0] fifo_head;
    logic q_empty;
    logic q_full;

    // Offset match, shared by write and read decode
    function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] off);
        addr_hit = (addr == off);
    endfunction : addr_hit

    // Widen a raw code to the data word by polarity
    function automatic logic [`SLCM_DATA_BITS-1:0] widen(input logic [`SLCM_ADC_BITS-1:0] code,
                                                        input logic unip);
        if (unip) begin
            widen = {{(`SLCM_DATA_BITS-`SLCM_ADC_BITS){1'b0}}, code};
        end else begin
            widen = {{(`SLCM_DATA_BITS-`SLCM_ADC_BITS){code[`SLCM_ADC_BITS-1]}}, code};
        end
    endfunction : widen

    // Bus decode of direct registers and windowed strobes
    always_comb begin
        wr_lo = bus_wr && addr_hit(bus_addr, `SLCM_OFF_ENTRY_LO); // [R2]
        wr_hi = bus_wr && addr_hit(bus_addr, `SLCM_OFF_ENTRY_HI); // [R3]
        // A window write or read both count [R23]
        win_access = (bus_wr && addr_hit(bus_addr, `SLCM_OFF_WIN_WDATA)) ||
                     (bus_rd && addr_hit(bus_addr, `SLCM_OFF_WIN_RDATA));
        // Data bits play no part in the strobes [R21]
        list_clr = win_access && (s_ff.win_ptr == `SLCM_WIN_LIST_CLR); // [R19]
        fifo_clr = win_access && (s_ff.win_ptr == `SLCM_WIN_FIFO_CLR); // [R20]
        fifo_pop = bus_rd && addr_hit(bus_addr, `SLCM_OFF_FIFO_DATA);
    end

    // Entry from both halves, newest half taken live
    always_comb begin
        logic [15:0] lo;
        logic [15:0] hi;
        lo = wr_lo ? bus_wdata : s_ff.lo_word;
        hi = wr_hi ? bus_wdata : s_ff.hi_word;
        // Unused bits are not stored; the host keeps them zero [R6]
        new_entry.end_flag = lo[`SLCM_LO_END_BIT];                  // [R4]
        new_entry.noise_inject_on = lo[`SLCM_LO_DITHER_BIT];        // [R7]
        new_entry.unipolar = lo[`SLCM_LO_UNIP_BIT];                 // [R9]
        new_entry.gain = lo[`SLCM_LO_GAIN_MSB:0];                   // [R11]
        new_entry.input_kind_code = hi[`SLCM_HI_KIND_MSB:`SLCM_HI_KIND_LSB]; // [R12]
        new_entry.chan = hi[`SLCM_HI_CHAN_MSB:0];                   // [R13]
        // Commit when both halves are in, in either order [R24]
        commit = (wr_lo || s_ff.got_lo) && (wr_hi || s_ff.got_hi) && (wr_lo || wr_hi);
    end

    // Entry under conversion and its routing
    assign cur_entry = s_ff.mem[s_ff.rd_idx];

    slcm_router u_router (
        .entry(cur_entry),
        .route(cur_route)
    );

    // Last stored entry closes a scan even without its flag
    assign last_slot = ({1'b0, s_ff.rd_idx} == (s_ff.count - 1'b1));

    // Result into the queue unless the entry is skipped, reserved or invalid [R22] [R18]
    assign res_push = (s_ff.scan_st == slcm_pkg::SCAN_RUN) && conv_done && cur_route.acquire;
    assign res_data = widen(adc_code, cur_entry.unipolar); // [R10]

    slcm_sample_fifo u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .push(res_push),
        .push_data(res_data),
        .pop(fifo_pop),
        .head(fifo_head),
        .empty(q_empty),
        .full(q_full),
        .flush(fifo_clr)
    );

    // Next state of the whole block
    always_comb begin
        nxt_s = s_ff;
        nxt_s.scan_done = 1'b0;

        // Window pointer write
        if (bus_wr && addr_hit(bus_addr, `SLCM_OFF_WIN_PTR)) begin
            nxt_s.win_ptr = bus_wdata[7:0]; // [R23]
        end

        // Half-word capture
        if (wr_lo) begin
            nxt_s.lo_word = bus_wdata;
            nxt_s.got_lo = 1'b1;
        end
        if (wr_hi) begin
            nxt_s.hi_word = bus_wdata;
            nxt_s.got_hi = 1'b1;
        end

        // Store the finished entry; a full list drops it
        if (commit) begin
            nxt_s.got_lo = 1'b0;
            nxt_s.got_hi = 1'b0;
            if (s_ff.count != (`SLCM_IDXW+1)'(`SLCM_DEPTH)) begin
                nxt_s.mem[s_ff.count[`SLCM_IDXW-1:0]] = new_entry; // [R1]
                nxt_s.count = s_ff.count + 1'b1;                   // [R24]
            end
        end

        // Scan sequencer
        case (s_ff.scan_st)
            slcm_pkg::SCAN_IDLE: begin
                // An empty list cannot start
                if (scan_start && (s_ff.count != '0)) begin
                    nxt_s.scan_st = slcm_pkg::SCAN_RUN;
                    nxt_s.scan_active = 1'b1;
                end
            end
            slcm_pkg::SCAN_RUN: begin
                // Each conversion, skip or not, uses one slot [R18]
                if (conv_done) begin
                    if (cur_entry.end_flag || last_slot) begin
                        nxt_s.scan_st = slcm_pkg::SCAN_IDLE; // [R4]
                        nxt_s.scan_active = 1'b0;
                        nxt_s.scan_done = 1'b1;
                        if (interval_mode && !last_slot) begin
                            // Next sequence in the same list [R5]
                            nxt_s.rd_idx = s_ff.rd_idx + 1'b1;
                        end else begin
                            // Back to the first entry [R25]
                            nxt_s.rd_idx = '0;
                        end
                    end else begin
                        nxt_s.rd_idx = s_ff.rd_idx + 1'b1; // [R1]
                    end
                end
            end
            default: begin
                nxt_s.scan_st = slcm_pkg::SCAN_IDLE;
                nxt_s.scan_active = 1'b0;
            end
        endcase

        // List erase wins over a same-cycle commit and stops any scan [R19]
        if (list_clr) begin
            nxt_s.mem = '0;
            nxt_s.count = '0;
            nxt_s.rd_idx = '0;
            nxt_s.got_lo = 1'b0;
            nxt_s.got_hi = 1'b0;
            nxt_s.scan_st = slcm_pkg::SCAN_IDLE;
            nxt_s.scan_active = 1'b0;
        end

        // Front end controls follow the entry under conversion
        nxt_s.route = cur_route;
        nxt_s.gain = cur_entry.gain;          // [R11]
        nxt_s.unipolar = cur_entry.unipolar;  // [R9]
        // Variant with fixed dither ignores the bit [R8]
        nxt_s.dither = DITHER_FIXED ? 1'b1 : cur_entry.noise_inject_on; // [R7]

        // Read data; unmapped and write-only offsets read zero
        if (fifo_pop) begin
            nxt_s.rdata = q_empty ? 16'h0000 : fifo_head;
        end else if (bus_rd) begin
            nxt_s.rdata = 16'h0000;
        end

        nxt_s.fifo_empty = q_empty;
        nxt_s.fifo_full = q_full;
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_ff <= '0;
            s_ff.route.pos_sel <= `SLCM_SEL_NONE;
            s_ff.route.neg_sel <= `SLCM_SEL_NONE;
            s_ff.fifo_empty <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state flops
    assign bus_rdata = s_ff.rdata;
    assign scan_active = s_ff.scan_active;
    assign scan_done = s_ff.scan_done;
    assign amp_pos_sel = s_ff.route.pos_sel;
    assign amp_neg_sel = s_ff.route.neg_sel;
    assign amp_gain = s_ff.gain;
    assign adc_unipolar = s_ff.unipolar;
    assign dither_on = s_ff.dither;
    assign entry_acquire = s_ff.route.acquire;
    assign fifo_empty = s_ff.fifo_empty;
    assign fifo_full = s_ff.fifo_full;

endmodule : slcm_scan_list

//--- slcm_scan_list_checker.sv
// Concurrent checks on the scan list configuration memory ports.
`include "slcm_defs.svh"
module slcm_scan_list_checker #(
    parameter logic DITHER_FIXED = 1'b0
) (
    // Clock and reset
    input logic ref_clk,
    input logic rstn,
    // Bus
    input logic bus_wr,
    input logic bus_rd,
    input logic [15:0] bus_rdata,
    // Timing controller
    input logic scan_start,
    input logic conv_done,
    input logic scan_active,
    input logic scan_done,
    // Front end and queue
    input logic [4:0] amp_pos_sel,
    input logic [4:0] amp_neg_sel,
    input logic dither_on,
    input logic entry_acquire,
    input logic fifo_empty,
    input logic fifo_full
);
    // One clock domain
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_DONE_AFTER_CONV: assert property (scan_done |-> $past(conv_done) && $past(scan_active))
        else $error("done without conversion");
    AST_DONE_PULSE: assert property (scan_done |=> !scan_done)
        else $error("done too long");
    AST_END_MARKED: assert property ($fell(scan_active) && !$past(bus_wr) && !$past(bus_rd) |-> scan_done)
        else $error("stop without done");
    AST_START_CAUSE: assert property ($rose(scan_active) |-> $past(scan_start))
        else $error("unrequested start");
    AST_CAL_GAIN: assert property (amp_pos_sel == `SLCM_SEL_REF5 |-> amp_neg_sel == `SLCM_SEL_GND)
        else $error("ref not on ground");
    AST_DIFF_PAIR: assert property (amp_neg_sel < 5'h10 |-> amp_pos_sel + 5'h08 == amp_neg_sel)
        else $error("bad differential pair");
    AST_SENSE_PIN: assert property (amp_neg_sel == `SLCM_SEL_SENSE |-> amp_pos_sel < 5'h10)
        else $error("sense without pin");
    AST_NO_ROUTE: assert property (amp_pos_sel == `SLCM_SEL_NONE |->
        amp_neg_sel == `SLCM_SEL_NONE && !entry_acquire) else $error("unrouted acquire");
    AST_QUEUE_FLAGS: assert property (!(fifo_empty && fifo_full))
        else $error("empty and full");
    AST_RDATA_HOLD: assert property ($past(rstn) && !$past(bus_rd) |-> $stable(bus_rdata))
        else $error("read data moved");
    AST_DITHER_FIXED: assert property ($past(rstn) && DITHER_FIXED |-> dither_on)
        else $error("fixed dither off");

    // Main scenarios reached
    CV_DONE: cover property (scan_done);
    CV_SKIP_SLOT: cover property (scan_active && !entry_acquire);
    CV_REF: cover property (amp_pos_sel == `SLCM_SEL_REF5);
endmodule : slcm_scan_list_checker

bind slcm_scan_list slcm_scan_list_checker #(.DITHER_FIXED(DITHER_FIXED)) u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .scan_start(scan_start), .conv_done(conv_done), .scan_active(scan_active), .scan_done(scan_done),
    .amp_pos_sel(amp_pos_sel), .amp_neg_sel(amp_neg_sel), .dither_on(dither_on),
    .entry_acquire(entry_acquire), .fifo_empty(fifo_empty), .fifo_full(fifo_full)
);

//--- slcm_host_model.sv
// Host processor model on the card I/O bus.
module slcm_host_model #(
    parameter logic DITHER_FIXED = 1'b0
) (
    // Clock
    input logic ref_clk,
    // Bus driven by the host
    output logic [4:0] bus_addr,
    output logic [15:0] bus_wdata,
    output logic bus_wr,
    output logic bus_rd,
    input logic [15:0] bus_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        bus_addr = 5'h1F;
        bus_wdata = 16'h0000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    end

    // One write strobe; unused bits of the two entry words forced to zero
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = (a == 5'h10) ? (d & 16'h8307) | {6'h00, DITHER_FIXED, 9'h000} : d;
        if (a == 5'h12) v = d & 16'h700F;
        @(negedge ref_clk);
        bus_addr = a;
        bus_wdata = v;
        bus_wr = 1'b1;
        @(negedge ref_clk);
        bus_wr = 1'b0;
        // Released lines show the inverse, not the old value
        bus_addr = ~a;
        bus_wdata = ~v;
    endtask : wr

    // One read strobe; data taken once it has settled
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        bus_addr = a;
        bus_rd = 1'b1;
        @(negedge ref_clk);
        bus_rd = 1'b0;
        bus_addr = ~a;
        @(negedge ref_clk);
        d = bus_rdata;
    endtask : rd

    // Windowed access: pointer first, then data port
    task automatic win(input logic [7:0] off, input logic via_rd);
        logic [15:0] d;
        wr(5'h00, {8'h00, off});
        if (via_rd) rd(5'h04, d);
        else wr(5'h02, 16'hFFFF);
    endtask : win
endmodule : slcm_host_model

//--- tb_top.sv
// Self-checking bench for the scan list configuration memory.
`include "slcm_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // Compare and count
    `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end

    logic ref_clk = 1'b0; // 10 MHz
    logic rstn = 1'b0; // Active low
    logic [4:0] bus_addr;
    logic [15:0] bus_wdata, bus_rdata;
    logic bus_wr, bus_rd;
    logic scan_start = 1'b0; // Timing controller side
    logic interval_mode = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] adc_code = 12'h000;
    logic scan_active, scan_done, adc_unipolar, dither_on, entry_acquire, fifo_empty, fifo_full;
    logic [4:0] amp_pos_sel, amp_neg_sel;
    logic [2:0] amp_gain;
    int error_cnt = 0;
    int num_checks = 0;

    always #50 ref_clk = ~ref_clk;

    slcm_host_model u_host (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

    slcm_scan_list dut (.ref_clk(ref_clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .scan_start(scan_start),
        .interval_mode(interval_mode), .conv_done(conv_done), .adc_code(adc_code),
        .scan_active(scan_active), .scan_done(scan_done), .amp_pos_sel(amp_pos_sel),
        .amp_neg_sel(amp_neg_sel), .amp_gain(amp_gain), .adc_unipolar(adc_unipolar),
        .dither_on(dither_on), .entry_acquire(entry_acquire), .fifo_empty(fifo_empty), .fifo_full(fifo_full));

    // Expected {pos, neg, acquire} per kind and channel
    function automatic logic [10:0] exp_route(input logic [2:0] k, input logic [3:0] c);
        if (k == `SLCM_KIND_CAL && c == `SLCM_CAL_OFFSET) return {`SLCM_SEL_GND, `SLCM_SEL_GND, 1'b1};
        if (k == `SLCM_KIND_CAL && c == `SLCM_CAL_GAIN) return {`SLCM_SEL_REF5, `SLCM_SEL_GND, 1'b1};
        if (k == `SLCM_KIND_DIFF && !c[3]) return {1'b0, c, 2'b01, c[2:0], 1'b1};
        if (k == `SLCM_KIND_FSE) return {1'b0, c, `SLCM_SEL_SENSE, 1'b1};
        if (k == `SLCM_KIND_GSE) return {1'b0, c, `SLCM_SEL_GND, 1'b1};
        return {`SLCM_SEL_NONE, `SLCM_SEL_NONE, 1'b0};
    endfunction : exp_route

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    // Start pulse, then bounded wait for the scan
    task automatic start_scan(input logic expect_run);
        @(negedge ref_clk);
        scan_start = 1'b1;
        @(negedge ref_clk);
        scan_start = 1'b0;
        for (int k = 0; k < 4 && scan_active !== 1'b1; k++) @(negedge ref_clk);
        `CHK(scan_active, expect_run)
    endtask : start_scan

    // One conversion result for the current entry
    task automatic convert(input logic [11:0] c);
        @(negedge ref_clk);
        conv_done = 1'b1;
        adc_code = c;
        @(negedge ref_clk);
        conv_done = 1'b0;
        adc_code = ~c;
    endtask : convert

    // Bounded wait for the done pulse; a hang ends the run
    task automatic wait_done();
        for (int k = 0; k < 8 && scan_done !== 1'b1; k++) @(negedge ref_clk);
        if (scan_done !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        `CHK(scan_active, 1'b0)
    endtask : wait_done

    // Values held while reset is low
    task automatic s_reset();
        repeat (20) @(negedge ref_clk);
        `CHK(fifo_empty, 1'b1)
        `CHK(scan_active, 1'b0)
        rstn = 1'b1;
    endtask : s_reset

    // Every kind, reserved codes, both polarities; queue read back
    task automatic s_entries();
        logic [15:0] lo [8] = '{16'h0000, 16'h0101, 16'h0203, 16'h0002, 16'h0104, 16'h0005, 16'h0006, 16'h8007};
        logic [15:0] hi [8] = '{16'h0000, 16'h0005, 16'h1007, 16'h1008, 16'h200F, 16'h7003, 16'h4001, 16'h3000};
        logic [11:0] code [8] = '{12'h7FF, 12'hFFF, 12'h800, 12'h123, 12'h456, 12'h789, 12'h111, 12'hABC};
        logic [15:0] q [$];
        logic [15:0] d;
        logic [10:0] r;
        for (int i = 0; i < 8; i++) begin
            // Odd entries send the high half first
            if (i % 2) u_host.wr(5'h12, hi[i]);
            u_host.wr(5'h10, lo[i]);
            if (!(i % 2)) u_host.wr(5'h12, hi[i]);
        end
        start_scan(1'b1);
        for (int i = 0; i < 8; i++) begin
            repeat (3) @(negedge ref_clk);
            `CHK(amp_gain, lo[i][2:0])
            `CHK(adc_unipolar, lo[i][8])
            `CHK(dither_on, lo[i][9])
            r = exp_route(hi[i][14:12], hi[i][3:0]);
            `CHK({amp_pos_sel, amp_neg_sel, entry_acquire}, r)
            if (r[0]) q.push_back({{4{code[i][11] && !lo[i][8]}}, code[i]});
            convert(code[i]);
        end
        wait_done();
        foreach (q[j]) begin
            u_host.rd(5'h1C, d);
            `CHK(d, q[j])
        end
        repeat (2) @(negedge ref_clk);
        `CHK(fifo_empty, 1'b1)
    endtask : s_entries

    // Erased list refuses a scan; next entry lands in slot 0
    task automatic s_clear();
        u_host.win(`SLCM_WIN_LIST_CLR, 1'b0);
        start_scan(1'b0);
        u_host.wr(5'h10, 16'h0000);
        u_host.wr(5'h12, 16'h2009);
        repeat (2) @(negedge ref_clk);
        `CHK(amp_pos_sel, 5'h09)
        `CHK(amp_neg_sel, `SLCM_SEL_SENSE)
    endtask : s_clear

    // Several end flags, both stepping modes, queue full and flush
    task automatic s_interval();
        u_host.win(`SLCM_WIN_LIST_CLR, 1'b1);
        for (int e = 1; e < 4; e++) begin
            u_host.wr(5'h10, {e < 3, 15'h0000});
            u_host.wr(5'h12, 16'h3000 | 16'(e));
        end
        // Eight scans: the last slot wraps, eight results fill the queue
        for (int m = 0; m < 8; m++) begin
            interval_mode = (m != 0);
            start_scan(1'b1);
            convert(12'h001);
            wait_done();
            repeat (2) @(negedge ref_clk);
            `CHK(amp_pos_sel, 5'(m % 3 + 1))
        end
        `CHK({fifo_empty, fifo_full}, 2'b01)
        u_host.win(`SLCM_WIN_FIFO_CLR, 1'b1);
        repeat (2) @(negedge ref_clk);
        `CHK({fifo_empty, fifo_full}, 2'b10)
    endtask : s_interval

    // Main sequence
    initial begin
        s_reset();
        s_entries();
        s_clear();
        s_interval();
        stop_test();
    end
endmodule : tb_top
